// *** src/global_clock_source_select.sv ***
// clock control block for one global clock network: source choice, network
// gating, pll reference feed and the apb register file that configures it.
// assumes user logic drives the dynamic select and enable on pclk, and the
// clock sources arrive as plain nets from pins and plls.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - pins, pll, dual pins, logic drive network
// - two-bit logic select picks dynamic source
// - dual pin and logic only statically reachable
// - static choice frozen during user mode
// - two of four pll outputs enter
// - five counters per pll, two routable
// - logic gates network on and off
// - dual pin sourced net never feeds pll
// - logic sourced net never feeds pll
// - only pll or pin nets feed pll
// - switch signal muxes pll reference clock
// - one corner pin feeds, other stays io
// - small parts have networks zero to nine
// - at most twenty or thirty blocks
// - transceiver left side takes no pins
// - unused pins reach fabric via fabric registers
// - pins carry clears, presets, enables too
// - enable sampled on falling clock edge
// - gating leaves source plls untouched; a pll fed from this net sees it
module global_clock_source_select
   import clk_ctrl_pkg::*;
#(
   parameter int NET_INDEX    = 0,
   parameter bit SMALL_PART   = 1'b0,
   parameter bit TRANSCEIVER  = 1'b0,
   parameter bit LEFT_SIDE    = 1'b0,
   parameter int BLOCK_COUNT  = 20
) (
   // apb clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // user logic control
   input  wire logic        user_mode,
   input  wire logic [1:0]  dyn_select,
   input  wire logic        net_enable,
   input  wire logic        pll_switch_dyn,
   input  wire logic        manual_switchover,
   // candidate sources
   input  wire logic [1:0]  ded_clk_pin,
   input  wire logic [4:0]  pll_a_ctr,
   input  wire logic [4:0]  pll_b_ctr,
   input  wire logic        dual_purpose_clock_pin,
   input  wire logic [1:0]  corner_dual_purpose_clock_pin,
   input  wire logic        logic_element,
   // network and pll feed
   output var  logic        global_clock_net,
   output var  logic        pll_reference_input,
   output var  logic        pll_ref_allowed,
   // pins handed to fabric
   output var  logic [1:0]  ded_pin_to_fabric,
   output var  logic        corner_spare_to_fabric
);

   // ----------------------------------------------------------------------
   // elaboration-time limits
   // ----------------------------------------------------------------------
   localparam int BLOCK_LIMIT = TRANSCEIVER ? MAX_BLOCKS_XCVR : MAX_BLOCKS_PLAIN;
   // an index beyond the part's range or a block count over the limit marks
   // the network absent, so it never toggles
   localparam bit NET_EXISTS = (!SMALL_PART || (NET_INDEX <= SMALL_LAST_NET))
                               && (BLOCK_COUNT <= BLOCK_LIMIT);
   localparam bit PINS_PRESENT = !(TRANSCEIVER && LEFT_SIDE);

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   src_cfg_s    cfg;
   logic [31:0] cfg_word;
   logic        setup_phase;
   logic        access_phase;
   logic        addr_hit;
   logic        wr_locked;
   logic        wr_bad_ctr;
   logic        wr_refused;
   logic [31:0] next_prdata;

   // ----------------------------------------------------------------------
   // synchronisers for pins and the other clock domain
   // ----------------------------------------------------------------------
   logic [1:0]  pin_meta;
   logic [1:0]  pin_sync;
   logic        spare_meta;
   logic        spare_sync;
   logic        gate_meta;
   logic        gate_sync;
   logic        gate_state;

   // pins used as plain inputs pass fabric registers, not io registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta   <= 2'b00;
         pin_sync   <= 2'b00;
         spare_meta <= 1'b0;
         spare_sync <= 1'b0;
         gate_meta  <= 1'b0;
         gate_sync  <= 1'b0;
      end else begin
         pin_meta   <= ded_clk_pin;
         pin_sync   <= pin_meta;
         spare_meta <= cfg.corner_pick ? corner_dual_purpose_clock_pin[0]
                                       : corner_dual_purpose_clock_pin[1];
         spare_sync <= spare_meta;
         gate_meta  <= gate_state;
         gate_sync  <= gate_meta;
      end
   end

   // fabric copies, also usable as clears, presets or enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ded_pin_to_fabric      <= 2'b00;
         corner_spare_to_fabric <= 1'b0;
      end else begin
         ded_pin_to_fabric      <= PINS_PRESENT ? pin_sync : 2'b00;
         corner_spare_to_fabric <= spare_sync;
      end
   end

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   always_comb begin
      setup_phase  = psel & ~penable;
      access_phase = psel & penable;
      addr_hit     = (paddr == SRC_CFG_OFS) || (paddr == STATUS_OFS) ||
                     (paddr == PIN_FABRIC_OFS) || (paddr == NET_INFO_OFS);
      // static choices are configuration data: logic cannot move them later
      wr_locked    = pwrite & user_mode & (paddr == SRC_CFG_OFS);
      // only counters c0..c4 exist
      wr_bad_ctr   = pwrite & (paddr == SRC_CFG_OFS) &
                     ((pwdata[FIRST_CTR_LSB +: 3] >= 3'(PLL_OUTPUTS)) |
                      (pwdata[SECOND_CTR_LSB +: 3] >= 3'(PLL_OUTPUTS)));
      wr_refused   = ~addr_hit | wr_locked | wr_bad_ctr |
                     (pwrite & (paddr != SRC_CFG_OFS));
      pready       = 1'b1;
      pslverr      = access_phase & wr_refused;
   end

   // configuration word, written only outside user mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_word <= SRC_CFG_RESET;
      end else if (access_phase && pwrite && !wr_refused) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               cfg_word[b*8 +: 8] <= pwdata[b*8 +: 8];
            end
         end
      end
   end

   always_comb begin
      cfg = src_cfg_s'(cfg_word[12:0]);
   end

   // ----------------------------------------------------------------------
   // read data, captured in the setup cycle
   // ----------------------------------------------------------------------
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         SRC_CFG_OFS: begin
            next_prdata = {19'h0_0000, cfg_word[12:0]};
         end
         STATUS_OFS: begin
            next_prdata = {24'h00_0000, PINS_PRESENT, NET_EXISTS, user_mode,
                           pll_ref_allowed, gate_sync, net_enable, dyn_select};
         end
         PIN_FABRIC_OFS: begin
            next_prdata = {29'h0000_0000, corner_spare_to_fabric, ded_pin_to_fabric};
         end
         NET_INFO_OFS: begin
            next_prdata = {27'h000_0000, 5'(NET_INDEX)};
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------------------------------------
   // candidate sources
   // ----------------------------------------------------------------------
   logic [1:0] pin_cand;
   logic [1:0] pll_cand;
   logic       corner_feed;
   logic       dynamic_clk;
   logic       selected_clk;
   logic       gate_enable;

   always_comb begin
      // left side of a transceiver part has no dedicated pin inputs
      pin_cand    = PINS_PRESENT ? ded_clk_pin : 2'b00;
      // each pll offers two of its five counters; two of the four enter here
      pll_cand[0] = cfg.cand2_pll ? pll_b_ctr[cfg.first_ctr]
                                  : pll_a_ctr[cfg.first_ctr];
      pll_cand[1] = cfg.cand3_pll ? pll_b_ctr[cfg.second_ctr]
                                  : pll_a_ctr[cfg.second_ctr];
      // only one corner pin of the pair reaches the block
      corner_feed = cfg.corner_pick ? corner_dual_purpose_clock_pin[1]
                                    : corner_dual_purpose_clock_pin[0];
   end

   // dynamic mux: pins and plls only
   always_comb begin
      case (dyn_sel_e'(dyn_select))
         DYN_PIN0: dynamic_clk = pin_cand[0];
         DYN_PIN1: dynamic_clk = pin_cand[1];
         DYN_PLL0: dynamic_clk = pll_cand[0];
         DYN_PLL1: dynamic_clk = pll_cand[1];
         default:  dynamic_clk = 1'b0;
      endcase
   end

   // static mux: dual pins and logic never come through the dynamic path
   always_comb begin
      case (cfg.static_src)
         SRC_DYNAMIC: selected_clk = dynamic_clk;
         SRC_DUALPIN: selected_clk = dual_purpose_clock_pin | corner_feed;
         SRC_LOGIC:   selected_clk = logic_element;
         default:     selected_clk = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // network gate
   // ----------------------------------------------------------------------
   // the gate sits after the mux, so the source plls never see it; pll_reference_input does when the switch picks this net
   always_comb begin
      gate_enable = net_enable & ~cfg.static_off & NET_EXISTS;
   end

   net_clock_gate gate_cell (
      .clk_in   (selected_clk),
      .clk_out  (global_clock_net),
      .rst_n    (presetn),
      .enable   (gate_enable),
      .enable_q (gate_state)
   );

   // ----------------------------------------------------------------------
   // pll reference feed
   // ----------------------------------------------------------------------
   // a net fed by a dual pin or by logic is barred from pll inputs
   always_comb begin
      pll_ref_allowed = (cfg.static_src == SRC_DYNAMIC) && NET_EXISTS;
   end

   // switch is static config, or user logic during manual switchover
   logic ref_switch;

   always_comb begin
      ref_switch = manual_switchover ? pll_switch_dyn : cfg.ref_switch;
      if (ref_switch && pll_ref_allowed) begin
         pll_reference_input = global_clock_net;
      end else if (!ref_switch) begin
         pll_reference_input = pin_cand[0];
      end else begin
         pll_reference_input = 1'b0;
      end
   end

endmodule

`default_nettype wire

// *** src/clk_ctrl_pkg.sv ***
// package for the global clock source select block: register map, fields,
// reset values and source encodings.
// assumes a 32-bit apb slave on pclk and clock inputs arriving as plain nets.
package clk_ctrl_pkg;

   // ----------------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [11:0] SRC_CFG_OFS    = 12'h000;
   localparam logic [11:0] STATUS_OFS     = 12'h004;
   localparam logic [11:0] PIN_FABRIC_OFS = 12'h008;
   localparam logic [11:0] NET_INFO_OFS   = 12'h00c;

   // ----------------------------------------------------------------------
   // source configuration fields
   // ----------------------------------------------------------------------
   localparam int STATIC_SRC_LSB  = 0;   // two bits
   localparam int CORNER_PICK_BIT = 2;
   localparam int CAND2_PLL_BIT   = 3;
   localparam int CAND3_PLL_BIT   = 4;
   localparam int FIRST_CTR_LSB   = 5;   // three bits
   localparam int SECOND_CTR_LSB  = 8;   // three bits
   localparam int REF_SWITCH_BIT  = 11;
   localparam int STATIC_OFF_BIT  = 12;
   localparam logic [31:0] SRC_CFG_RESET = 32'h0000_0020; // counters c0 and c1

   // ----------------------------------------------------------------------
   // network and device limits
   // ----------------------------------------------------------------------
   localparam int PLL_OUTPUTS       = 5;
   localparam int PLL_ROUTED        = 2;
   localparam int SMALL_LAST_NET    = 9;
   localparam int MAX_BLOCKS_PLAIN  = 20;
   localparam int MAX_BLOCKS_XCVR   = 30;

   // ----------------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_DYNAMIC = 2'b00,
      SRC_DUALPIN = 2'b01,
      SRC_LOGIC   = 2'b10,
      SRC_SPARE   = 2'b11
   } static_src_e;

   typedef enum logic [1:0] {
      DYN_PIN0 = 2'b00,
      DYN_PIN1 = 2'b01,
      DYN_PLL0 = 2'b10,
      DYN_PLL1 = 2'b11
   } dyn_sel_e;

   // static choices gathered for the clock path
   typedef struct packed {
      logic        static_off;
      logic        ref_switch;
      logic [2:0]  second_ctr;
      logic [2:0]  first_ctr;
      logic        cand3_pll;
      logic        cand2_pll;
      logic        corner_pick;
      static_src_e static_src;
   } src_cfg_s;

endpackage

// *** src/net_clock_gate.sv ***
// network clock gate: enable caught on the falling clock edge, then anded.
// assumes clk_in is the already selected network clock.
`timescale 1ns/1ps
`default_nettype none

module net_clock_gate (
   // clock in and out
   input  wire logic clk_in,
   output var  logic clk_out,
   // control
   input  wire logic rst_n,
   input  wire logic enable,
   output var  logic enable_q
);

   // ----------------------------------------------------------------------
   // falling-edge enable latch
   // ----------------------------------------------------------------------
   // sampling on the low phase means a change never cuts a high phase short
   always_ff @(negedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         enable_q <= 1'b0;
      end else begin
         enable_q <= enable;
      end
   end

   // and gate: no runt pulse since enable_q only moves while clk_in is low
   always_comb begin
      clk_out = clk_in & enable_q;
   end

endmodule

`default_nettype wire

// *** test/user_fabric_model.sv ***
// user fabric model: drives the dynamic select and the network enable.
// assumes the bench asks for a change with a one-cycle req on pclk.
`timescale 1ns/1ps
`default_nettype none

module user_fabric_model #(
   parameter int SETTLE = 20
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // bench request
   input  wire logic       req,
   input  wire logic [1:0] want,
   input  wire logic       gate_on,
   output var  logic       busy,
   // control into the block
   output var  logic [1:0] dyn_select,
   output var  logic       net_enable
);
   int cnt;

   // ---------------------------------------------------------------
   // switch sequence
   // ---------------------------------------------------------------
   // gate off first so no half-cut pulse of either clock escapes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dyn_select <= 2'b00;
         net_enable <= 1'b0;
         busy       <= 1'b0;
         cnt        <= 0;
      end else if (req && !busy) begin
         net_enable <= 1'b0;
         busy       <= 1'b1;
         cnt        <= 0;
      end else if (busy) begin
         cnt <= cnt + 1;
         if (cnt == 2) begin
            dyn_select <= want;
         end
         // wait several cycles of the slowest new clock before enabling
         if (cnt == SETTLE) begin
            net_enable <= gate_on;
            busy       <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// *** test/clk_ctrl_checker_assertions.sv ***
// checker for the clock control block: refusals, pll feed and gating.
// assumes it is bound to global_clock_source_select, one pclk domain.
`timescale 1ns/1ps
`default_nettype none

module clk_ctrl_checker
   import clk_ctrl_pkg::*;
(
   // apb side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // control and clock path
   input wire logic        user_mode,
   input wire logic [1:0]  dyn_select,
   input wire logic        net_enable,
   input wire logic        pll_switch_dyn,
   input wire logic        manual_switchover,
   input wire logic [1:0]  ded_clk_pin,
   input wire logic        global_clock_net,
   input wire logic        pll_reference_input,
   input wire logic        pll_ref_allowed
);
   logic       cfg_wr;
   logic       st_rd;
   logic [4:0] off_cnt;

   // accepted config write, status read setup
   assign cfg_wr = psel && penable && pwrite && paddr == SRC_CFG_OFS && pstrb[0] && !pslverr;
   assign st_rd  = psel && !penable && !pwrite && paddr == STATUS_OFS;

   // cycles with enable low; saturates so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_cnt <= 5'h00;
      end else if (net_enable) begin
         off_cnt <= 5'h00;
      end else if (off_cnt != 5'h1f) begin
         off_cnt <= off_cnt + 5'h01;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_user_lock: assert property (psel && penable && pwrite && user_mode |-> pslverr)
      else $error("write taken in user mode");
   chk_ctr_range: assert property (psel && penable && pwrite && paddr == SRC_CFG_OFS && pwdata[7:5] > 3'h4 |-> pslverr)
      else $error("counter index above four taken");
   chk_ref_dual: assert property (cfg_wr && pwdata[1:0] == 2'b01 |=> !pll_ref_allowed)
      else $error("dual pin net offered to pll");
   chk_ref_logic: assert property (cfg_wr && pwdata[1:0] == 2'b10 |=> !pll_ref_allowed)
      else $error("logic net offered to pll");
   chk_ref_pin: assert property (cfg_wr && pwdata[1:0] == 2'b00 |=> pll_ref_allowed)
      else $error("dynamic net not offered to pll");
   // twenty pclk cycles hold a falling edge of the slowest source
   chk_gate_off: assert property (off_cnt > 5'h13 |-> !global_clock_net)
      else $error("network runs while disabled");
   chk_status_sel: assert property (st_rd |=> prdata[1:0] == $past(dyn_select) && prdata[2] == $past(net_enable))
      else $error("status shows wrong select or enable");
   chk_ref_switch: assert property (manual_switchover && !pll_switch_dyn |-> pll_reference_input == ded_clk_pin[0])
      else $error("pll reference not from pin");

   cov_cfg_wr: cover property (cfg_wr);
   cov_st_rd: cover property (st_rd);
   cov_gated: cover property (off_cnt == 5'h14);
endmodule

bind global_clock_source_select clk_ctrl_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
   .user_mode(user_mode), .dyn_select(dyn_select), .net_enable(net_enable),
   .pll_switch_dyn(pll_switch_dyn), .manual_switchover(manual_switchover),
   .ded_clk_pin(ded_clk_pin), .global_clock_net(global_clock_net),
   .pll_reference_input(pll_reference_input), .pll_ref_allowed(pll_ref_allowed)
);

`default_nettype wire

// *** test/global_clock_source_select_tb.sv ***
// testbench for the clock control block: apb master, free clock sources,
// user fabric model. assumes the package and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module global_clock_source_select_tb
   import clk_ctrl_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'hf;
   logic        pready, pslverr, user_mode = 1'b0, pll_switch_dyn = 1'b0, manual_switchover = 1'b0;
   logic [1:0]  ded_clk_pin = 2'b00, corner = 2'b00, dyn_select, want = 2'b00, fab_pins;
   logic [4:0]  pll_a_ctr = 5'h00, pll_b_ctr = 5'h00;
   logic        dual_pin = 1'b0, logic_src = 1'b0, req = 1'b0, gate_on = 1'b0, busy;
   logic        net_enable, global_clock_net, pll_reference_input, pll_ref_allowed, spare;
   logic [15:0] srcs;
   logic [1:0]  seen;
   int          mismatches = 0, comparisons = 0;

   // ---------------------------------------------------------------
   // clocks: every source except the corner pins toggles so the gate sees falling edges
   // ---------------------------------------------------------------
   always #2 pclk = ~pclk;
   always #3 ded_clk_pin[0] = ~ded_clk_pin[0];
   always #5 ded_clk_pin[1] = ~ded_clk_pin[1];
   always #6 dual_pin = ~dual_pin;
   always #9 logic_src = ~logic_src;
   for (genvar i = 0; i < 5; i++) begin : g_pll
      always #(4 + i) pll_a_ctr[i] = ~pll_a_ctr[i];
      always #(7 + i) pll_b_ctr[i] = ~pll_b_ctr[i];
   end
   // candidate sources by index, the network last
   assign srcs = {global_clock_net, 1'b0, logic_src, dual_pin | corner[0], ded_clk_pin, pll_b_ctr, pll_a_ctr};
   assign seen = {pll_reference_input, global_clock_net};

   global_clock_source_select u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .user_mode(user_mode), .dyn_select(dyn_select), .net_enable(net_enable),
      .pll_switch_dyn(pll_switch_dyn), .manual_switchover(manual_switchover),
      .ded_clk_pin(ded_clk_pin), .pll_a_ctr(pll_a_ctr), .pll_b_ctr(pll_b_ctr),
      .dual_purpose_clock_pin(dual_pin), .corner_dual_purpose_clock_pin(corner),
      .logic_element(logic_src), .global_clock_net(global_clock_net),
      .pll_reference_input(pll_reference_input), .pll_ref_allowed(pll_ref_allowed),
      .ded_pin_to_fabric(fab_pins), .corner_spare_to_fabric(spare)
   );
   user_fabric_model u_user (
      .pclk(pclk), .presetn(presetn), .req(req), .want(want), .gate_on(gate_on),
      .busy(busy), .dyn_select(dyn_select), .net_enable(net_enable)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // apb transfer; reads compare under a mask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait limit here: the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk({31'h0, pslverr}, {31'h0, e});
      if (!w) chk(prdata & m, d & m);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // ask the user model for a select and enable, wait until it settles
   task automatic switch_to(input logic [1:0] s, input logic on);
      int n;
      @(posedge pclk);
      req     <= 1'b1;
      want    <= s;
      gate_on <= on;
      @(posedge pclk);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy !== 1'b0 && n < 100);
      if (busy !== 1'b0) mismatches++;
      repeat (10) @(posedge pclk);
   endtask

   // samples between source edges, which all fall on whole ns
   task automatic follow(input int o, input int k);
      int bad;
      bad = 0;
      @(posedge pclk);
      #0.5;
      repeat (40) begin
         if (seen[o] !== srcs[k]) bad++;
         #1;
      end
      chk(32'(bad), 32'h0);
   endtask

   task automatic final_report();
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk({31'h0, global_clock_net}, 32'h0);
      acc(1'b0, SRC_CFG_OFS, SRC_CFG_RESET, 32'hffff_ffff, 1'b0);
      acc(1'b0, STATUS_OFS, 32'h0, 32'h27, 1'b0);
      acc(1'b0, NET_INFO_OFS, 32'h0, 32'h1f, 1'b0);
   endtask

   task automatic t_dynamic();
      int exp_k [4] = '{10, 11, 1, 0};
      for (int s = 0; s < 4; s++) begin
         switch_to(2'(s), 1'b1);
         follow(0, exp_k[s]);
         acc(1'b0, STATUS_OFS, 32'(s) | 32'h4, 32'h7, 1'b0);
      end
   endtask

   task automatic t_gate();
      switch_to(2'b00, 1'b0);
      repeat (25) @(posedge pclk);
      follow(0, 14);
      switch_to(2'b00, 1'b1);
      follow(0, 10);
      // static off bit gates the net even with the user enable high
      acc(1'b1, SRC_CFG_OFS, 32'h1020, 32'h0, 1'b0);
      repeat (10) @(posedge pclk);
      follow(0, 14);
      acc(1'b1, SRC_CFG_OFS, SRC_CFG_RESET, 32'h0, 1'b0);
      repeat (10) @(posedge pclk);
      follow(0, 10);
   endtask

   task automatic t_pll();
      acc(1'b1, SRC_CFG_OFS, 32'h88, 32'h0, 1'b0);
      switch_to(2'b10, 1'b1);
      follow(0, 9);
      acc(1'b1, SRC_CFG_OFS, 32'ha8, 32'h0, 1'b1);
      acc(1'b0, SRC_CFG_OFS, 32'h88, 32'h1fff, 1'b0);
   endtask

   task automatic t_static();
      acc(1'b1, SRC_CFG_OFS, 32'h21, 32'h0, 1'b0);
      switch_to(2'b01, 1'b1);
      follow(0, 12);
      chk({31'h0, pll_ref_allowed}, 32'h0);
      acc(1'b1, SRC_CFG_OFS, 32'h22, 32'h0, 1'b0);
      repeat (10) @(posedge pclk);
      follow(0, 13);
      chk({31'h0, pll_ref_allowed}, 32'h0);
      acc(1'b1, SRC_CFG_OFS, 32'h23, 32'h0, 1'b0);
      repeat (10) @(posedge pclk);
      follow(0, 14);
      chk({31'h0, pll_ref_allowed}, 32'h0);
      acc(1'b1, SRC_CFG_OFS, 32'h20, 32'h0, 1'b0);
      @(posedge pclk);
      chk({31'h0, pll_ref_allowed}, 32'h1);
   endtask

   task automatic t_lock();
      @(posedge pclk);
      user_mode <= 1'b1;
      acc(1'b1, SRC_CFG_OFS, 32'h21, 32'h0, 1'b1);
      acc(1'b0, SRC_CFG_OFS, 32'h20, 32'h1fff, 1'b0);
      acc(1'b0, STATUS_OFS, 32'h20, 32'h20, 1'b0);
      acc(1'b1, STATUS_OFS, 32'h0, 32'h0, 1'b1);
      acc(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      user_mode <= 1'b0;
   endtask

   task automatic t_ref();
      @(posedge pclk);
      manual_switchover <= 1'b1;
      follow(1, 10);
      @(posedge pclk);
      pll_switch_dyn <= 1'b1;
      follow(1, 15);
      @(posedge pclk);
      manual_switchover <= 1'b0;
      pll_switch_dyn    <= 1'b0;
   endtask

   task automatic t_corner();
      @(posedge pclk);
      corner <= 2'b10;
      repeat (5) @(posedge pclk);
      chk({31'h0, spare}, 32'h1);
      acc(1'b0, PIN_FABRIC_OFS, 32'h4, 32'h4, 1'b0);
      // dual pin path: the spare corner pin sits high and must not reach the net
      acc(1'b1, SRC_CFG_OFS, 32'h21, 32'h0, 1'b0);
      repeat (10) @(posedge pclk);
      follow(0, 12);
      @(posedge pclk);
      corner <= 2'b00;
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_dynamic();
      t_gate();
      t_pll();
      t_static();
      t_lock();
      t_ref();
      t_corner();
      final_report();
   end

   // the whole run needs a few microseconds
   initial begin
      #50000;
      mismatches++;
      final_report();
   end
endmodule

`default_nettype wire
